// file: csss_pkg.sv
// Shared constants and types for the clock source select and start-up block.
`default_nettype none
package csss_pkg;
  typedef enum logic [2:0] {
    CSSS_FUSE    = 3'b000,
    CSSS_RST_CK  = 3'b001,
    CSSS_RST_WD  = 3'b011,
    CSSS_RUN     = 3'b010,
    CSSS_SLEEP   = 3'b110,
    CSSS_WAKE    = 3'b111,
    CSSS_FAULT   = 3'b100
  } csss_state_t;

  typedef enum logic [2:0] {
    CSSS_SRC_EXT   = 3'h0,
    CSSS_SRC_RC4   = 3'h1,
    CSSS_SRC_RC8   = 3'h2,
    CSSS_SRC_WDOG  = 3'h3,
    CSSS_SRC_XTAL  = 3'h4,
    CSSS_SRC_NONE  = 3'h7
  } csss_src_t;

  typedef enum logic [1:0] {
    CSSS_SLP_IDLE    = 2'h0,
    CSSS_SLP_PDOWN   = 2'h1,
    CSSS_SLP_STANDBY = 2'h2
  } csss_slp_t;

  typedef struct packed {
    logic [3:0] srcSel;
    logic [1:0] startup_time_field;
    logic       div8;
  } csss_fuse_t;

  typedef struct packed {
    logic core;
    logic periph;
    logic progmem;
  } csss_clk_en_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } csss_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } csss_avm_rsp_t;

  // Source-select fuse codes.
  localparam logic [3:0] SRC_CODE_EXT  = 4'h0;
  localparam logic [3:0] SRC_CODE_RC4  = 4'h2;
  localparam logic [3:0] SRC_CODE_RC8  = 4'h4;
  localparam logic [3:0] SRC_CODE_WDOG = 4'h6;

  // A fuse bit at zero is programmed, at one unprogrammed.
  localparam logic FUSE_PROGRAMMED = 1'b0;

  // Delivered fuse state, held until the first capture.
  localparam csss_fuse_t FUSE_DEFAULT = '{srcSel: 4'h4, startup_time_field: 2'h2, div8: 1'b0};

  // Prescaler selects: divide by 2 to the power of the select.
  localparam logic [3:0] PRESC_SEL_DIV1 = 4'h0;
  localparam logic [3:0] PRESC_SEL_DIV8 = 4'h3;
  localparam logic [3:0] PRESC_SEL_MAX  = 4'h8;

  // Start-up counts in oscillator cycles.
  localparam logic [15:0] RST_CK_CYCLES      = 16'h000e;
  localparam logic [15:0] RC_WAKE_CYCLES     = 16'h0006;
  localparam logic [15:0] XTAL_WAKE_SHORT    = 16'h0102;
  localparam logic [15:0] XTAL_WAKE_MID      = 16'h0400;
  localparam logic [15:0] WDOG_SHORT_CYCLES  = 16'h0200;

  // Register byte offsets.
  localparam logic [3:0] REG_CTRL_OFS   = 4'h0;
  localparam logic [3:0] REG_STATUS_OFS = 4'h4;
  localparam logic [3:0] REG_FUSE_OFS   = 4'h8;
endpackage
`default_nettype wire

// file: csss_prescaler.sv
// System clock prescaler: one output tick for every 2**sel source ticks.
`default_nettype none
module csss_prescaler #(
  parameter int SEL_W = 4
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             srcTick,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  sysTick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } csss_presc_st_t;

  csss_presc_st_t st_r;
  csss_presc_st_t st_nxt;
  logic [15:0]    limit;

  always_comb begin
    limit = 16'((32'd1 << sel) - 32'd1);
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (srcTick) begin
      if (st_r.cnt >= limit) begin
        st_nxt.cnt = 16'h0000;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sysTick = st_r.tick;
endmodule
`default_nettype wire

// file: csss_clock_control.sv
// Clock source selection, start-up timing, prescaling and domain gating.
`default_nettype none
module csss_clock_control #(
  parameter int WDOG_LONG_CYCLES = 8192,
  parameter int XTAL_WAKE_LONG   = 16384
) (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [3:0]             sourceSelectField,
  input  wire logic [1:0]             startupTimeField,
  input  wire logic                   divByEightFuse,
  input  wire logic                   extClkIn,
  input  wire logic                   rc4Tick,
  input  wire logic                   rc8Tick,
  input  wire logic                   watchdogTick,
  input  wire logic                   oscAmpInput,
  output logic                        oscAmpOutput,
  output logic                        oscAmpOutputEn,
  output logic                        oscRun,
  input  wire logic                   sleepEnter,
  input  wire logic [1:0]             sleepMode,
  input  wire logic                   wakeEvent,
  output csss_pkg::csss_clk_en_t      clkEn,
  output logic                        coreRunning,
  input  wire csss_pkg::csss_avm_req_t avsReq,
  output csss_pkg::csss_avm_rsp_t     avsRsp
);
  typedef struct packed {
    csss_pkg::csss_state_t  state;
    csss_pkg::csss_fuse_t   fuse;
    csss_pkg::csss_slp_t    slpMode;
    logic [15:0]            cnt;
    logic [3:0]             prescSel;
    logic                   extPrev;
    logic                   ampPrev;
    logic                   ampOut;
    logic                   ampOe;
    logic                   oscRun;
    csss_pkg::csss_clk_en_t clkEn;
    logic                   running;
    csss_pkg::csss_avm_rsp_t rsp;
  } csss_ctl_st_t;

  localparam logic [15:0] WDOG_LONG = 16'(WDOG_LONG_CYCLES);
  localparam logic [15:0] XTAL_LONG = 16'(XTAL_WAKE_LONG);

  csss_ctl_st_t       st_r;
  csss_ctl_st_t       st_nxt;
  csss_pkg::csss_src_t src;
  logic               srcTick;
  logic               sysTick;
  logic [15:0]        wakeCycles;
  logic [15:0]        wdogCycles;
  logic               sutReserved;
  logic               wrHit;
  logic [31:0]        rdData;

  function automatic csss_pkg::csss_src_t decodeSrc(input logic [3:0] code);
    csss_pkg::csss_src_t s;
    s = csss_pkg::CSSS_SRC_NONE;
    if (code[3]) begin
      s = csss_pkg::CSSS_SRC_XTAL;
    end else begin
      case (code)
        csss_pkg::SRC_CODE_EXT:  s = csss_pkg::CSSS_SRC_EXT;
        csss_pkg::SRC_CODE_RC4:  s = csss_pkg::CSSS_SRC_RC4;
        csss_pkg::SRC_CODE_RC8:  s = csss_pkg::CSSS_SRC_RC8;
        csss_pkg::SRC_CODE_WDOG: s = csss_pkg::CSSS_SRC_WDOG;
        default:                 s = csss_pkg::CSSS_SRC_NONE;
      endcase
    end
    return s;
  endfunction

  // Divides the selected clock before it reaches any domain.
  csss_prescaler #(
    .SEL_W (4)
  ) u_presc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .srcTick  (srcTick),
    .sel      (st_r.prescSel),
    .sysTick  (sysTick)
  );

  // Start-up counts from the captured fuses.
  always_comb begin
    src = decodeSrc(st_r.fuse.srcSel);
    wakeCycles = csss_pkg::RC_WAKE_CYCLES;
    wdogCycles = 16'h0000;
    sutReserved = 1'b0;
    if (src == csss_pkg::CSSS_SRC_XTAL) begin
      case ({st_r.fuse.srcSel[0], st_r.fuse.startup_time_field})
        3'h0, 3'h1: wakeCycles = csss_pkg::XTAL_WAKE_SHORT;
        3'h2, 3'h3, 3'h4: wakeCycles = csss_pkg::XTAL_WAKE_MID;
        default: wakeCycles = XTAL_LONG;
      endcase
      case ({st_r.fuse.srcSel[0], st_r.fuse.startup_time_field})
        3'h0, 3'h3, 3'h6: wdogCycles = csss_pkg::WDOG_SHORT_CYCLES;
        3'h1, 3'h4, 3'h7: wdogCycles = WDOG_LONG;
        default: wdogCycles = 16'h0000;
      endcase
    end else begin
      case (st_r.fuse.startup_time_field)
        2'h0: wdogCycles = 16'h0000;
        2'h1: wdogCycles = csss_pkg::WDOG_SHORT_CYCLES;
        2'h2: wdogCycles = WDOG_LONG;
        default: sutReserved = 1'b1;
      endcase
    end
  end

  // Selected source tick; a reserved code yields no clock at all.
  always_comb begin
    case (src)
      csss_pkg::CSSS_SRC_EXT:  srcTick = extClkIn & ~st_r.extPrev;
      csss_pkg::CSSS_SRC_RC4:  srcTick = rc4Tick;
      csss_pkg::CSSS_SRC_RC8:  srcTick = rc8Tick;
      csss_pkg::CSSS_SRC_WDOG: srcTick = watchdogTick;
      csss_pkg::CSSS_SRC_XTAL: srcTick = oscAmpInput & ~st_r.ampPrev;
      default:                 srcTick = 1'b0;
    endcase
    if (!st_r.oscRun) begin
      srcTick = 1'b0;
    end
  end

  // Register read mux.
  always_comb begin
    rdData = 32'h0000_0000;
    case (avsReq.address)
      csss_pkg::REG_CTRL_OFS:   rdData = {28'h0000000, st_r.prescSel};
      csss_pkg::REG_STATUS_OFS: rdData = {22'h000000, st_r.slpMode, st_r.running,
                                          src, 1'b0, st_r.state};
      csss_pkg::REG_FUSE_OFS:   rdData = {25'h0000000, st_r.fuse};
      default:                  rdData = 32'h0000_0000;
    endcase
  end

  assign wrHit = avsReq.write && !st_r.rsp.waitrequest &&
                 avsReq.address == csss_pkg::REG_CTRL_OFS && avsReq.byteenable[0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.extPrev = extClkIn;
    st_nxt.ampPrev = oscAmpInput;

    // Bus slave: one waitrequest-high cycle, then one low cycle with data.
    st_nxt.rsp.waitrequest = !((avsReq.read || avsReq.write) && st_r.rsp.waitrequest);
    if (avsReq.read && st_r.rsp.waitrequest) begin
      st_nxt.rsp.readdata = rdData;
    end
    if (wrHit) begin
      st_nxt.prescSel = (avsReq.writedata[3:0] > csss_pkg::PRESC_SEL_MAX) ?
                        csss_pkg::PRESC_SEL_MAX : avsReq.writedata[3:0];
    end

    case (st_r.state)
      csss_pkg::CSSS_FUSE: begin
        st_nxt.fuse = '{srcSel: sourceSelectField, startup_time_field: startupTimeField,
                        div8: divByEightFuse};
        st_nxt.prescSel = (divByEightFuse == csss_pkg::FUSE_PROGRAMMED) ?
                          csss_pkg::PRESC_SEL_DIV8 : csss_pkg::PRESC_SEL_DIV1;
        st_nxt.cnt = 16'h0000;
        st_nxt.state = csss_pkg::CSSS_RST_CK;
      end
      csss_pkg::CSSS_RST_CK: begin
        if (src == csss_pkg::CSSS_SRC_NONE || sutReserved) begin
          st_nxt.state = csss_pkg::CSSS_FAULT;
        end else if (srcTick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (st_r.cnt + 16'h0001 >= csss_pkg::RST_CK_CYCLES) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.state = (wdogCycles == 16'h0000) ? csss_pkg::CSSS_RUN :
                           csss_pkg::CSSS_RST_WD;
          end
        end
      end
      csss_pkg::CSSS_RST_WD: begin
        if (watchdogTick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (st_r.cnt + 16'h0001 >= wdogCycles) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.state = csss_pkg::CSSS_RUN;
          end
        end
      end
      csss_pkg::CSSS_RUN: begin
        if (sleepEnter) begin
          st_nxt.slpMode = csss_pkg::csss_slp_t'(sleepMode);
          st_nxt.state = csss_pkg::CSSS_SLEEP;
        end
      end
      csss_pkg::CSSS_SLEEP: begin
        // Wake events arrive from logic that needs no peripheral clock.
        if (wakeEvent) begin
          st_nxt.cnt = 16'h0000;
          st_nxt.state = (st_r.slpMode == csss_pkg::CSSS_SLP_IDLE) ?
                         csss_pkg::CSSS_RUN : csss_pkg::CSSS_WAKE;
        end
      end
      csss_pkg::CSSS_WAKE: begin
        if (srcTick) begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
          if (st_r.cnt + 16'h0001 >= wakeCycles) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.state = csss_pkg::CSSS_RUN;
          end
        end
      end
      csss_pkg::CSSS_FAULT: begin
        st_nxt.state = csss_pkg::CSSS_FAULT;
      end
      default: begin
        st_nxt.state = csss_pkg::CSSS_FAULT;
      end
    endcase

    st_nxt.running = (st_nxt.state == csss_pkg::CSSS_RUN);
    // The selected oscillator stops only in fuse capture, in power-down and on faults.
    st_nxt.oscRun = !(st_nxt.state == csss_pkg::CSSS_FAULT ||
                      st_nxt.state == csss_pkg::CSSS_FUSE ||
                      (st_nxt.state == csss_pkg::CSSS_SLEEP &&
                       st_nxt.slpMode == csss_pkg::CSSS_SLP_PDOWN));
    st_nxt.clkEn.core = sysTick && st_r.running;
    st_nxt.clkEn.periph = sysTick && (st_r.running ||
                          (st_r.state == csss_pkg::CSSS_SLEEP &&
                           st_r.slpMode == csss_pkg::CSSS_SLP_IDLE));
    st_nxt.clkEn.progmem = sysTick && st_r.running;

    st_nxt.ampOe = (decodeSrc(st_nxt.fuse.srcSel) == csss_pkg::CSSS_SRC_XTAL) &&
                   st_nxt.oscRun;
    st_nxt.ampOut = st_nxt.ampOe && !oscAmpInput;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '{state: csss_pkg::CSSS_FUSE, fuse: csss_pkg::FUSE_DEFAULT,
                slpMode: csss_pkg::CSSS_SLP_IDLE, cnt: 16'h0000,
                prescSel: csss_pkg::PRESC_SEL_DIV8, extPrev: 1'b0, ampPrev: 1'b0,
                ampOut: 1'b0, ampOe: 1'b0, oscRun: 1'b0, clkEn: '0, running: 1'b0,
                rsp: '{readdata: 32'h0000_0000, waitrequest: 1'b1}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign oscAmpOutput = st_r.ampOut;
  assign oscAmpOutputEn = st_r.ampOe;
  assign oscRun = st_r.oscRun;
  assign clkEn = st_r.clkEn;
  assign coreRunning = st_r.running;
  assign avsRsp = st_r.rsp;
endmodule
`default_nettype wire

// file: csss_clock_control_properties.sv
// Concurrent checks on the ports of the clock control block.
`default_nettype none
module csss_clock_control_properties #(
  parameter int WDOG_LONG_CYCLES = 8192,
  parameter int XTAL_WAKE_LONG   = 16384
) (
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  input wire logic                    oscAmpInput,
  input wire logic                    oscAmpOutput,
  input wire logic                    oscAmpOutputEn,
  input wire logic                    oscRun,
  input wire csss_pkg::csss_clk_en_t  clkEn,
  input wire logic                    coreRunning,
  input wire csss_pkg::csss_avm_req_t avsReq,
  input wire csss_pkg::csss_avm_rsp_t avsRsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_core_needs_run: assert property (!coreRunning [*4] |-> !clkEn.core)
    else $error("core domain enabled while core halted");
  a_progmem_with_core: assert property (clkEn.progmem == clkEn.core)
    else $error("program memory domain apart from core domain");
  a_stopped_quiet: assert property (!oscRun [*4] |-> clkEn == '0)
    else $error("domain enabled with oscillator stopped");
  a_amp_invert: assert property (
    oscAmpOutputEn && $past(oscAmpOutputEn) |-> oscAmpOutput == !$past(oscAmpInput))
    else $error("amplifier output is not the inverted input");
  a_amp_quiet: assert property (!oscAmpOutputEn |-> !oscAmpOutput)
    else $error("amplifier output driven while disabled");
  a_wake_delay: assert property ($rose(oscRun) |-> !coreRunning [*6])
    else $error("core started before start-up count");
  a_periph_pulse: assert property (clkEn.periph |=> !clkEn.periph)
    else $error("peripheral enable longer than one cycle");
  a_bus_one_wait: assert property (
    (avsReq.read || avsReq.write) && avsRsp.waitrequest |=> !avsRsp.waitrequest)
    else $error("bus answer not after one wait cycle");
  a_bus_ack_single: assert property (!avsRsp.waitrequest |=> avsRsp.waitrequest)
    else $error("bus acknowledge longer than one cycle");

  c_core_runs: cover property (coreRunning && clkEn.core);
  c_idle_periph: cover property (!coreRunning && clkEn.periph);
  c_crystal_runs: cover property (oscAmpOutputEn && coreRunning);
endmodule

bind csss_clock_control csss_clock_control_properties #(
  .WDOG_LONG_CYCLES(WDOG_LONG_CYCLES),
  .XTAL_WAKE_LONG  (XTAL_WAKE_LONG)
) props_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .oscAmpInput(oscAmpInput),
  .oscAmpOutput(oscAmpOutput), .oscAmpOutputEn(oscAmpOutputEn), .oscRun(oscRun),
  .clkEn(clkEn), .coreRunning(coreRunning), .avsReq(avsReq), .avsRsp(avsRsp)
);
`default_nettype wire

// file: csss_osc_model.sv
// Behavioural crystal on the amplifier pins and a free-running external clock.
`default_nettype none
module csss_osc_model #(
  parameter int EXT_HALF = 3
) (
  input  wire logic core_clk,
  input  wire logic ampOut,
  input  wire logic ampOutEn,
  output logic      ampIn,
  output logic      extClk
);
  timeunit 1ns;
  timeprecision 1ps;
  int extCnt = 0;
  initial begin
    ampIn = 1'b0;
    extClk = 1'b0;
  end
  // The crystal returns the amplifier output; an undriven input keeps changing.
  always @(posedge core_clk) begin
    ampIn <= ampOutEn ? ampOut : !ampIn;
    extCnt <= (extCnt == EXT_HALF - 1) ? 0 : extCnt + 1;
    if (extCnt == EXT_HALF - 1) begin
      extClk <= !extClk;
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the clock control block.
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, div8 = 1'b0;
  logic [3:0] srcSel = 4'h4;
  logic [1:0] startup_time_field = 2'h2, sleepMode = 2'h0;
  logic rc4Tick = 1'b0, rc8Tick = 1'b0, wdTick = 1'b0, sleepEnter = 1'b0, wakeEvent = 1'b0;
  logic extClk, ampIn, ampOut, ampOutEn, oscRun, coreRunning;
  logic [31:0] rd;
  csss_pkg::csss_clk_en_t clkEn;
  csss_pkg::csss_avm_req_t req = '0;
  csss_pkg::csss_avm_rsp_t rsp;
  int cyc = 0, wdCnt = 0, n_errors = 0, checks_done = 0, n, cc, pc, lo;

  always #2.5 core_clk = !core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    rc8Tick <= cyc % 2 == 0;
    rc4Tick <= cyc % 4 == 0;
    wdTick <= cyc % 8 == 0;
    wdCnt <= sys_rst ? 0 : wdCnt + int'(wdTick && !coreRunning);
  end

  csss_clock_control #(.WDOG_LONG_CYCLES(16), .XTAL_WAKE_LONG(20)) csss_clock_control_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .sourceSelectField(srcSel),
    .startupTimeField(startup_time_field), .divByEightFuse(div8), .extClkIn(extClk), .rc4Tick(rc4Tick),
    .rc8Tick(rc8Tick), .watchdogTick(wdTick), .oscAmpInput(ampIn), .oscAmpOutput(ampOut),
    .oscAmpOutputEn(ampOutEn), .oscRun(oscRun), .sleepEnter(sleepEnter),
    .sleepMode(sleepMode), .wakeEvent(wakeEvent), .clkEn(clkEn),
    .coreRunning(coreRunning), .avsReq(req), .avsRsp(rsp));
  csss_osc_model csss_osc_model_inst (.core_clk(core_clk), .ampOut(ampOut),
    .ampOutEn(ampOutEn), .ampIn(ampIn), .extClk(extClk));

  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.waitrequest !== 1'b0 && k < 50);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic restart(input logic [3:0] s, input logic [1:0] t, input logic d);
    srcSel <= s;
    startup_time_field <= t;
    div8 <= d;
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic waitRun(input int lim);
    n = 0;
    while (coreRunning !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) begin
      n_errors++;
      complete_run();
    end
  endtask

  // Counts domain enable pulses over a fixed window after a settling gap.
  task automatic cnt();
    cc = 0;
    pc = 0;
    repeat (8) @(posedge core_clk);
    repeat (64) begin
      @(posedge core_clk);
      cc += int'(clkEn.core === 1'b1);
      pc += int'(clkEn.periph === 1'b1);
    end
  endtask

  task automatic pulse(input logic sl, input logic [1:0] m);
    sleepEnter <= sl;
    wakeEvent <= !sl;
    sleepMode <= m;
    @(posedge core_clk);
    sleepEnter <= 1'b0;
    wakeEvent <= 1'b0;
  endtask

  function automatic logic [2:0] expSrc(input logic [3:0] c);
    if (c[3]) return 3'h4;
    if (c[0]) return 3'h7;
    return {1'b0, c[2:1]};
  endfunction

  initial begin
    for (int t = 0; t < 3; t++) begin
      restart(4'h4, t[1:0], 1'b0);
      waitRun(5000);
      lo = t == 0 ? 0 : t == 1 ? 512 : 16;
      `CHK("reset delay", 1'b1, wdCnt >= lo && wdCnt <= lo + 8)
    end
    srcSel <= 4'h0;
    div8 <= 1'b1;
    bus(0, 4'h8, 0);
    `CHK("fuse", 32'h24, rd)
    bus(0, 4'h4, 0);
    `CHK("status", 8'ha2, rd[7:0])
    bus(0, 4'h0, 0);
    `CHK("prescale", 32'h3, rd)
    cnt();
    `CHK("core div8", 4, cc)
    `CHK("periph div8", 4, pc)
    bus(1, 4'hc, 32'hffffffff);
    bus(0, 4'hc, 0);
    `CHK("unmapped", 32'h0, rd)
    bus(1, 4'h0, 32'h1);
    cnt();
    `CHK("core div2", 16, cc)
    pulse(1'b1, 2'h0);
    cnt();
    `CHK("idle core", 0, cc)
    `CHK("idle periph", 16, pc)
    pulse(1'b0, 2'h0);
    @(posedge core_clk);
    `CHK("idle wake", 1'b1, coreRunning)
    pulse(1'b1, 2'h1);
    cnt();
    `CHK("pdown off", 0, cc + pc)
    `CHK("pdown osc", 1'b0, oscRun)
    pulse(1'b0, 2'h1);
    waitRun(200);
    `CHK("wake time", 1'b1, n >= 10 && n <= 18)
    for (int c = 0; c < 16; c++) begin
      restart(c[3:0], 2'h0, 1'b1);
      repeat (4) @(posedge core_clk);
      bus(0, 4'h4, 0);
      `CHK("source", expSrc(c[3:0]), rd[6:4])
      if (c < 8 && c[0]) begin
        `CHK("reserved", 3'h4, rd[2:0])
        cnt();
        `CHK("reserved off", 0, cc + pc)
      end
    end
    bus(0, 4'h0, 0);
    `CHK("no divide", 32'h0, rd)
    restart(4'h4, 2'h3, 1'b1);
    repeat (4) @(posedge core_clk);
    bus(0, 4'h4, 0);
    `CHK("sut reserved", 3'h4, rd[2:0])
    restart(4'h9, 2'h0, 1'b0);
    waitRun(3000);
    `CHK("amp enable", 1'b1, ampOutEn)
    cnt();
    `CHK("crystal core", 2, cc)
    complete_run();
  end
endmodule
`default_nettype wire
